// ---- rtl/pch_pkg.sv ----
// package: constants, register offsets and carriers for the config header tail
package pch_pkg;

  // dword offsets within configuration space (byte address of each dword)
  localparam logic [7:0] PCH_OFF_CIS = 8'h28;
  localparam logic [7:0] PCH_OFF_SUBSYS = 8'h2C;
  localparam logic [7:0] PCH_OFF_CAPPTR = 8'h34;
  localparam logic [7:0] PCH_OFF_INTR = 8'h3C;
  localparam logic [7:0] PCH_OFF_PM = 8'hDC;
  localparam logic [7:0] PCH_OFF_PCIX = 8'hE4;
  localparam logic [7:0] PCH_OFF_MSI = 8'hF0;
  localparam logic [7:0] PCH_NEXT_END = 8'h00;

  // cis pointer values and fields
  localparam logic [31:0] PCH_CIS_ON = 32'h0000_0022;
  localparam logic [31:0] PCH_CIS_OFF = 32'h0000_0000;
  localparam logic [2:0] PCH_SPACE_CFG = 3'h0;
  localparam logic [2:0] PCH_SPACE_ROM = 3'h7;
  localparam logic [28:0] PCH_CIS_OFS_ON = 29'h0000_0004;

  // fixed bus figures
  localparam logic [7:0] PCH_MAX_LAT = 8'h00;
  localparam logic [7:0] PCH_MIN_GNT = 8'hFF;
  localparam logic [7:0] PCH_PIN_INTA = 8'h01;
  localparam logic [7:0] PCH_PIN_INTB = 8'h02;
  localparam logic [7:0] PCH_LINE_RST = 8'h00;

  // eeprom-derived configuration bits
  typedef struct packed {
    logic clkrun_en;
    logic bar32_sel;
    logic msi_dis;
    logic pcix_mode;
    logic both_funcs;
    logic [7:0] pin_field;
    logic [15:0] subsys_id;
    logic [15:0] subsys_vid;
  } pch_eecfg_t;

  // configuration access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pch_cfgreq_t;

endpackage

// ---- rtl/pch_sync.sv ----
// two-flop synchroniser for level inputs from outside the clock domain
`timescale 1ns/1ns
module pch_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // level in and out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] q_r;

  // first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_r <= '0;
      q_r <= '0;
    end
    else
    begin
      s1_r <= d_i;
      q_r <= s1_r;
    end
  end

  assign q_o = q_r;
endmodule

// ---- rtl/pch_cfg_tail.sv ----
// config header tail: cis pointer, subsystem ids, capability chain, latency, interrupt pin and line
//
// Operation
// - cis pointer 22h when clkrun and bar32
// - space field bits 2:0 encodes location
// - read-only offset 31:3, four when enabled
// - subsystem ids from eeprom, else defaults
// - capabilities pointer reads DCh
// - chain DCh to E4h to F0h to 00h
// - msi disabled in pci mode: pci-x ends
// - max latency 00h, min grant FFh
// - pin 1 means INTA, 2 INTB
// - both functions: pin from eeprom word
// - single function: pin always 1
`timescale 1ns/1ns
module pch_cfg_tail
  import pch_pkg::*;
#(
  parameter logic [15:0] DEF_SUBSYS_ID = 16'h0001,  // arbitrary neutral default
  parameter logic [15:0] DEF_SUBSYS_VID = 16'h0001  // arbitrary neutral default
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // eeprom load results; done and valid pass two stages, the config word is a level
  input wire logic ee_done_i,
  input wire logic ee_valid_i,
  input wire pch_pkg::pch_eecfg_t ee_cfg_i,
  // configuration access
  input wire pch_pkg::pch_cfgreq_t req_i,
  output logic ack_o,
  output logic [31:0] rdata_o,
  output logic hit_o,
  // msi capability present in the list
  output logic msi_listed_o,
  // stored interrupt line, for visibility only
  output logic [7:0] int_line_o
);
  import pch_pkg::*;

  // captured identity, stored line and answer registers
  logic [15:0] sid_r, sid_nxt;
  logic [15:0] svid_r, svid_nxt;
  logic loaded_r, loaded_nxt;
  logic [7:0] line_r, line_nxt;
  logic ack_r, ack_nxt;
  logic hit_r, hit_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic cis_en;
  logic [31:0] cis_val;
  logic [7:0] pin_val;
  logic msi_on;
  logic [7:0] pcix_next;
  logic sel;
  // synchronised load flags
  logic [1:0] ee_flags_s;
  logic ee_done_s;
  logic ee_valid_s;
  logic msi_r, msi_nxt;
  // read value of each dword in this group
  logic [31:0] subsys_dw;
  logic [31:0] cap_dw;
  logic [31:0] intr_dw;
  logic [31:0] pm_dw;
  logic [31:0] pcix_dw;
  logic [31:0] msi_dw;

  // cis pointer enable: 22h = offset 4 in bits 31:3, space 2 in bits 2:0
  assign cis_en = ee_cfg_i.clkrun_en & ee_cfg_i.bar32_sel;
  assign cis_val = cis_en ? PCH_CIS_ON : PCH_CIS_OFF;

  // msi can only be dropped in conventional pci mode
  assign msi_on = ee_cfg_i.pcix_mode | ~ee_cfg_i.msi_dis;
  assign pcix_next = msi_on ? PCH_OFF_MSI : PCH_NEXT_END;

  // interrupt pin: eeprom field only when both functions live
  assign pin_val = ee_cfg_i.both_funcs ? ee_cfg_i.pin_field : PCH_PIN_INTA;

  // load strobe and its valid flag cross two stages together, so the loader may run on its own clock;
  // the configuration word must stand still from the time done rises
  pch_sync #(
    .W(2)
  ) i_pch_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i({ee_valid_i, ee_done_i}),
    .q_o(ee_flags_s)
  );
  assign ee_done_s = ee_flags_s[0];
  assign ee_valid_s = ee_flags_s[1];

  // addresses this block answers; the msi dword drops out with its list entry
  assign sel = req_i.addr == PCH_OFF_CIS
    || req_i.addr == PCH_OFF_SUBSYS
    || req_i.addr == PCH_OFF_CAPPTR
    || req_i.addr == PCH_OFF_INTR
    || req_i.addr == PCH_OFF_PM
    || req_i.addr == PCH_OFF_PCIX
    || (req_i.addr == PCH_OFF_MSI && msi_on);

  // dword values; capability id bytes belong elsewhere and read zero
  assign subsys_dw = {sid_r, svid_r};
  assign cap_dw = {24'h000000, PCH_OFF_PM};
  assign intr_dw = {PCH_MAX_LAT, PCH_MIN_GNT, pin_val, line_r};
  assign pm_dw = {16'h0000, PCH_OFF_PCIX, 8'h00};
  assign pcix_dw = {16'h0000, pcix_next, 8'h00};
  assign msi_dw = {16'h0000, PCH_NEXT_END, 8'h00};  // last entry ends the list

  // subsystem_identifier capture: eeprom value once loaded, defaults if it failed
  always_comb
  begin
    sid_nxt = sid_r;
    svid_nxt = svid_r;
    loaded_nxt = loaded_r;
    if (ee_done_s && !loaded_r)
    begin
      loaded_nxt = 1'b1;
      if (ee_valid_s)
      begin
        sid_nxt = ee_cfg_i.subsys_id;
        svid_nxt = ee_cfg_i.subsys_vid;
      end
    end
  end

  // register the captured ids; reset restores the built-in defaults
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sid_r <= DEF_SUBSYS_ID;
      svid_r <= DEF_SUBSYS_VID;
      loaded_r <= 1'b0;
    end
    else
    begin
      sid_r <= sid_nxt;
      svid_r <= svid_nxt;
      loaded_r <= loaded_nxt;
    end
  end

  // interrupt line: only byte 0 of dword 3Ch is writable
  always_comb
  begin
    line_nxt = line_r;
    if (req_i.wr && req_i.addr == PCH_OFF_INTR && req_i.be[0])
    begin
      line_nxt = req_i.wdata[7:0];
    end
  end

  // register the stored line
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      line_r <= PCH_LINE_RST;
    end
    else
    begin
      line_r <= line_nxt;
    end
  end

  // read mux and one-cycle acknowledge
  always_comb
  begin
    ack_nxt = req_i.rd | req_i.wr;
    hit_nxt = (req_i.rd | req_i.wr) & sel;
    rdata_nxt = '0;
    if (req_i.rd)
    begin
      unique case (req_i.addr)
        PCH_OFF_CIS: rdata_nxt = cis_val;
        PCH_OFF_SUBSYS: rdata_nxt = subsys_dw;
        PCH_OFF_CAPPTR: rdata_nxt = cap_dw;
        PCH_OFF_INTR: rdata_nxt = intr_dw;
        PCH_OFF_PM: rdata_nxt = pm_dw;
        PCH_OFF_PCIX: rdata_nxt = pcix_dw;
        PCH_OFF_MSI: rdata_nxt = msi_on ? msi_dw : 32'h0000_0000;
        default: rdata_nxt = '0;
      endcase
    end
  end

  // msi listed flag, registered so the output comes from a flip-flop
  always_comb
  begin
    msi_nxt = msi_on;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      msi_r <= 1'b0;
    end
    else
    begin
      msi_r <= msi_nxt;
    end
  end

  // register the answer
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ack_r <= 1'b0;
      hit_r <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      ack_r <= ack_nxt;
      hit_r <= hit_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign ack_o = ack_r;
  assign hit_o = hit_r;
  assign rdata_o = rdata_r;
  assign msi_listed_o = msi_r;
  assign int_line_o = line_r;  // stored only, no routing effect
endmodule

// ---- verif/pch_host.sv ----
// host model: one configuration cycle at a time
`timescale 1ns/1ns
module pch_host
  import pch_pkg::*;
(
  // clock
  input wire logic clk_i,
  // request
  output pch_pkg::pch_cfgreq_t req_o
);
  initial req_o = '0;
  // one-cycle request, then the lines are scrambled once released
  task cfg(input logic rd, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk_i);
    req_o <= {rd, ~rd, a, be, d};
    @(negedge clk_i);
    req_o <= {2'b00, ~a, ~be, ~d};
  endtask
endmodule

// ---- verif/pch_cfg_tail_monitor.sv ----
// checker: answers of the config header tail
`timescale 1ns/1ns
module pch_cfg_tail_monitor
  import pch_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire pch_pkg::pch_eecfg_t ee_cfg_i,
  input wire pch_pkg::pch_cfgreq_t req_i,
  input wire logic ack_o,
  input wire logic [31:0] rdata_o,
  input wire logic msi_listed_o,
  input wire logic [7:0] int_line_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_ack_pulse: assert property ((req_i.rd | req_i.wr) |=> ack_o) else $error("bad ack");
  chk_ack_quiet: assert property (!(req_i.rd | req_i.wr) |=> !ack_o) else $error("stray ack");
  chk_ro_ignored: assert property (req_i.wr && req_i.addr == PCH_OFF_INTR && !req_i.be[0]
    |=> $stable(int_line_o)) else $error("line changed by upper bytes");
  chk_msi_flag: assert property ($past(rst_b_i) |-> msi_listed_o ==
    $past(ee_cfg_i.pcix_mode | ~ee_cfg_i.msi_dis)) else $error("bad msi flag");
  chk_cis_value: assert property (req_i.rd && req_i.addr == PCH_OFF_CIS |=> rdata_o ==
    ($past(ee_cfg_i.clkrun_en & ee_cfg_i.bar32_sel) ? PCH_CIS_ON : PCH_CIS_OFF)) else $error("bad cis");
  chk_cap_head: assert property (req_i.rd && req_i.addr == PCH_OFF_CAPPTR |=> rdata_o == 32'h0000_00DC)
    else $error("bad cap head");
  chk_pm_next: assert property (req_i.rd && req_i.addr == PCH_OFF_PM |=> rdata_o[15:8] == 8'hE4)
    else $error("bad pm next");
  chk_pcix_next: assert property (req_i.rd && req_i.addr == PCH_OFF_PCIX |=> rdata_o[15:8] ==
    ($past(ee_cfg_i.pcix_mode | ~ee_cfg_i.msi_dis) ? 8'hF0 : 8'h00)) else $error("bad pcix next");
  chk_lat_gnt: assert property (req_i.rd && req_i.addr == PCH_OFF_INTR |=> rdata_o[31:16] == 16'h00FF)
    else $error("bad lat gnt");
  chk_pin_single: assert property (req_i.rd && req_i.addr == PCH_OFF_INTR && !ee_cfg_i.both_funcs
    |=> rdata_o[15:8] == 8'h01) else $error("bad pin");
  chk_line_write: assert property (req_i.wr && req_i.addr == PCH_OFF_INTR && req_i.be[0]
    |=> int_line_o == $past(req_i.wdata[7:0])) else $error("bad line");
  cover property (req_i.wr ##1 ack_o);
  cover property (req_i.rd && req_i.addr == PCH_OFF_MSI);
  cover property (req_i.rd && req_i.addr == PCH_OFF_INTR && ee_cfg_i.both_funcs);
  cover property (req_i.wr && req_i.addr == PCH_OFF_INTR && !req_i.be[0]);
endmodule
bind pch_cfg_tail pch_cfg_tail_monitor i_pch_cfg_tail_monitor (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .ee_cfg_i(ee_cfg_i), .req_i(req_i), .ack_o(ack_o), .rdata_o(rdata_o), .msi_listed_o(msi_listed_o),
  .int_line_o(int_line_o));

// ---- verif/pch_cfg_tail_bench.sv ----
// bench: host reads and writes against the config header tail
`timescale 1ns/1ns
module pch_cfg_tail_bench;
  import pch_pkg::*;
  logic clk_i = 0, rst_b_i = 0, ee_done_i = 0, ee_valid_i = 0, ack_o, hit_o, msi_listed_o;
  pch_eecfg_t ee_cfg_i = '0;
  pch_cfgreq_t req_i;
  logic [31:0] rdata_o, r;
  logic [32:0] note, exp_q[$];
  logic [7:0] int_line_o;
  int error_cnt = 0, samples_checked = 0, seed = 64;
  always #25 clk_i = ~clk_i;
  pch_host i_pch_host (.clk_i(clk_i), .req_o(req_i));
  pch_cfg_tail i_pch_cfg_tail (.clk_i(clk_i), .rst_b_i(rst_b_i), .ee_done_i(ee_done_i), .ee_valid_i(ee_valid_i),
    .ee_cfg_i(ee_cfg_i), .req_i(req_i), .ack_o(ack_o), .rdata_o(rdata_o), .hit_o(hit_o),
    .msi_listed_o(msi_listed_o), .int_line_o(int_line_o));
  task print_verdict;
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task check32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  // hit flag of one answer
  task check_hit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t hit %b expected %b", $time, got, exp);
    end
  endtask
  // stored interrupt line
  task check_line(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t line %h expected %h", $time, got, exp);
    end
  endtask
  // msi listed flag
  task check_msi(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t msi flag %b expected %b", $time, got, exp);
    end
  endtask
  // each answer is paired with the oldest note
  always @(negedge clk_i)
    if (ack_o !== 1'b0)
    begin
      if (exp_q.size() == 0)
      begin
        error_cnt++;
        $display("[ERR] %0t answer with no request", $time);
      end
      else
      begin
        note = exp_q.pop_front();
        check32(rdata_o, note[31:0]);
        check_hit(hit_o, note[32]);
      end
    end
  task rd(input logic [7:0] a, input logic h, input logic [31:0] e);
    exp_q.push_back({h, e});
    i_pch_host.cfg(1'b1, a, 4'hF, 32'h0);
  endtask
  // a write answers too, with zero data and a hit
  task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    exp_q.push_back({1'b1, 32'h0000_0000});
    i_pch_host.cfg(1'b0, a, be, d);
  endtask
  task boot(input logic v, input pch_eecfg_t c);
    if (rst_b_i)
      repeat (2) @(negedge clk_i);
    rst_b_i = 0;
    ee_done_i = 0;
    ee_valid_i = v;
    ee_cfg_i = c;
    repeat (3) @(negedge clk_i);
    rst_b_i = 1;
    @(negedge clk_i);
    ee_done_i = 1;
    // the load strobe crosses two stages before the ids settle
    repeat (3) @(negedge clk_i);
  endtask
  initial
  begin
    r = $random(seed);
    boot(1'b1, {5'b11101, 8'h02, r});
    check_msi(msi_listed_o, 1'b0);
    rd(PCH_OFF_SUBSYS, 1'b1, r);
    rd(PCH_OFF_CIS, 1'b1, PCH_CIS_ON);
    rd(PCH_OFF_PM, 1'b1, 32'h0000_E400);
    rd(PCH_OFF_PCIX, 1'b1, 32'h0000_0000);
    rd(PCH_OFF_MSI, 1'b0, 32'h0000_0000);
    wr(PCH_OFF_CAPPTR, 4'hF, 32'hFFFF_FFFF);
    wr(PCH_OFF_INTR, 4'hF, r);
    check_line(int_line_o, r[7:0]);
    wr(PCH_OFF_INTR, 4'hE, ~r);
    check_line(int_line_o, r[7:0]);
    rd(PCH_OFF_CAPPTR, 1'b1, 32'h0000_00DC);
    rd(PCH_OFF_INTR, 1'b1, {16'h00FF, 8'h02, r[7:0]});
    boot(1'b0, {5'b10000, 8'h02, ~r});
    check_msi(msi_listed_o, 1'b1);
    check_line(int_line_o, PCH_LINE_RST);
    rd(PCH_OFF_SUBSYS, 1'b1, 32'h0001_0001);
    rd(PCH_OFF_CIS, 1'b1, PCH_CIS_OFF);
    rd(PCH_OFF_INTR, 1'b1, 32'h00FF_0100);
    rd(PCH_OFF_PCIX, 1'b1, 32'h0000_F000);
    rd(PCH_OFF_MSI, 1'b1, 32'h0000_0000);
    r = $random(seed);
    boot(1'b1, {5'b01111, 8'h01, r});
    check_msi(msi_listed_o, 1'b1);
    rd(PCH_OFF_SUBSYS, 1'b1, r);
    rd(PCH_OFF_PCIX, 1'b1, 32'h0000_F000);
    rd(PCH_OFF_INTR, 1'b1, 32'h00FF_0100);
    rd(PCH_OFF_CIS, 1'b1, PCH_CIS_OFF);
    repeat (3) @(negedge clk_i);
    if (exp_q.size() != 0)
    begin
      error_cnt++;
      $display("[ERR] %0t answers missing", $time);
    end
    print_verdict;
  end
  // watchdog cuts a hang short
  initial
  begin
    #100000;
    error_cnt++;
    print_verdict;
  end
endmodule
